// ==== shared/dch_arb_consts.svh ====
// register map, field positions, command codes and reset values of the d-channel arbiter
`ifndef DCH_ARB_CONSTS_SVH
`define DCH_ARB_CONSTS_SVH

`define ADDR_CTRL        8'h00
`define ADDR_CHAN_EN     8'h04
`define ADDR_CMD         8'h08
`define ADDR_IRQ_STAT    8'h0C
`define ADDR_IRQ_CLR     8'h10
`define ADDR_IRQ_EN      8'h14
`define ADDR_ARB_STAT    8'h18
`define ADDR_RX_DATA     8'h1C

`define CTRL_SERVE_ALL   0
`define CTRL_MODE_LSB    1
`define CTRL_RESET       3'h0
`define CLK_MODE_ARB     2'h3

`define CMD_MSG_DONE     8'h80
`define CMD_RX_RESET_BIT 6

`define IRQ_MSG_END      0
`define IRQ_RX_OVF       1

`define FLAG_BYTE        8'h7E
`define STATUS_OK        8'hA0
`define STATUS_LOST      8'h20

`endif

// ==== shared/dch_arb_pkg.sv ====
// types shared by the d-channel arbiter files
package dch_arb_pkg;

    typedef enum logic [2:0] {
        STATE_B     = 3'b000,
        FULL_SEL    = 3'b001,
        STATE_A     = 3'b010,
        RECV_FRAME  = 3'b011,
        LIMITED_SEL = 3'b100
    } arb_state_type;

    typedef struct packed {
        logic       frame_start;
        logic       byte_valid;
        logic       closing;
        logic [7:0] data;
    } rx_event_type;

endpackage

// ==== core/rx_deser.sv ====
// serial highway receiver front end: link clock sampling, flag hunt, byte assembly
`timescale 1ns/1ns
`include "dch_arb_consts.svh"

module rx_deser
    import dch_arb_pkg::*;
(
    // system
    input  wire logic   clk,
    input  wire logic   nrst,
    input  wire logic   rx_clr,
    // link pins
    input  wire logic   link_clk,
    input  wire logic   rxd,
    // events
    output rx_event_type ev
);

    logic       lclk_s1_reg, lclk_s2_reg, lclk_s3_reg;
    logic       rxd_s1_reg, rxd_s2_reg;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] bit_cnt_reg;
    logic       in_frame_reg;
    logic       got_data_reg;
    logic       rise;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lclk_s1_reg <= 1'b0;
            lclk_s2_reg <= 1'b0;
            lclk_s3_reg <= 1'b0;
            rxd_s1_reg  <= 1'b1;
            rxd_s2_reg  <= 1'b1;
        end else begin
            lclk_s1_reg <= link_clk;
            lclk_s2_reg <= lclk_s1_reg;
            lclk_s3_reg <= lclk_s2_reg;
            rxd_s1_reg  <= rxd;
            rxd_s2_reg  <= rxd_s1_reg;
        end
    end

    // data sampled on the rising link edge, lsb first
    assign rise       = lclk_s2_reg & ~lclk_s3_reg;
    assign shift_next = {rxd_s2_reg, shift_reg[7:1]};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg    <= 8'h00;
            bit_cnt_reg  <= 3'h0;
            in_frame_reg <= 1'b0;
            got_data_reg <= 1'b0;
            ev           <= '0;
        end else if (rx_clr) begin
            shift_reg    <= 8'h00;
            bit_cnt_reg  <= 3'h0;
            in_frame_reg <= 1'b0;
            got_data_reg <= 1'b0;
            ev           <= '0;
        end else begin
            ev <= '0;
            if (rise) begin
                shift_reg <= shift_next;
                if (shift_next == `FLAG_BYTE) begin
                    bit_cnt_reg <= 3'h0;
                    if (!in_frame_reg) begin
                        in_frame_reg   <= 1'b1;
                        got_data_reg   <= 1'b0;
                        ev.frame_start <= 1'b1;
                    end else if (got_data_reg) begin
                        // idle flags between frames do not close an empty frame
                        in_frame_reg <= 1'b0;
                        ev.closing   <= 1'b1;
                    end
                end else if (in_frame_reg) begin
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == 3'h7) begin
                        ev.byte_valid <= 1'b1;
                        ev.data       <= shift_next;
                        got_data_reg  <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

// ==== core/rx_fifo.sv ====
// receive byte fifo with flush and fill level
`timescale 1ns/1ns

module rx_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    // system
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          flush,
    // write side
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wr_data,
    // read side
    input  wire logic          rd_en,
    output logic      [W-1:0]  rd_data,
    // state
    output logic               full,
    output logic               empty,
    output logic      [AW:0]   level
);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr_reg, rptr_reg;
    logic [AW:0]   cnt_reg;
    logic          do_wr, do_rd;

    assign full    = (cnt_reg == (AW+1)'(DEPTH));
    assign empty   = (cnt_reg == '0);
    assign level   = cnt_reg;
    assign rd_data = mem[rptr_reg];
    assign do_wr   = wr_en & ~full;
    assign do_rd   = rd_en & ~empty;

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr_reg] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else if (flush) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            if (do_wr) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
            end
            if (do_rd) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

endmodule

// ==== core/dch_arbiter.sv ====
// d-channel arbiter sharing one hdlc receiver, with apb registers and overflow handling
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "dch_arb_consts.svh"

module dch_arbiter
    import dch_arb_pkg::*;
#(
    parameter int NCH   = 32,
    parameter int DEPTH = 64,
    parameter int IW    = $clog2(NCH),
    parameter int AW    = $clog2(DEPTH)
) (
    // system
    input  wire logic           CLK_SYS,
    input  wire logic           NRST,
    // apb slave
    input  wire logic           PSEL,
    input  wire logic           PENABLE,
    input  wire logic           PWRITE,
    input  wire logic [7:0]     PADDR,
    input  wire logic [31:0]    PWDATA,
    output logic      [31:0]    PRDATA,
    output logic                PREADY,
    output logic                PSLVERR,
    // serial highway
    input  wire logic           LINK_CLK,
    input  wire logic           RXD,
    input  wire logic [NCH-1:0] D_REQ,
    output logic      [NCH-1:0] BLOCKED,
    // interrupt
    output logic                IRQ
);

    arb_state_type  state_reg;
    rx_event_type   ev;
    logic [IW-1:0]  grant_reg;
    logic [2:0]     ctrl_reg;
    logic [NCH-1:0] chan_en_reg;
    logic [1:0]     irq_stat_reg, irq_en_reg, irq_set;
    logic [31:0]    prdata_reg;
    logic           ack_reg, stuck_reg;
    logic [NCH-1:0] req_s1_reg, req_s2_reg;
    logic [NCH-1:0] blocked_reg, blocked_next;
    logic [NCH-1:0] served, req;
    logic [IW:0]    pick;
    logic           access, wr_fire, rd_fire;
    logic           mode_wr, mode_leave, msg_done, rx_reset;
    logic           fifo_full, fifo_empty, fifo_wr, fifo_rd;
    logic [7:0]     fifo_wdata, fifo_rdata;
    logic [AW:0]    fifo_level;
    logic           frame_end_ind, lost_byte, lost_status, stuck_frame;

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `ADDR_CTRL) || (a == `ADDR_CHAN_EN) || (a == `ADDR_CMD) ||
               (a == `ADDR_IRQ_STAT) || (a == `ADDR_IRQ_CLR) || (a == `ADDR_IRQ_EN) ||
               (a == `ADDR_ARB_STAT) || (a == `ADDR_RX_DATA);
    endfunction

    // first requester at or after start, wrapping: the token search
    function automatic logic [IW:0] next_req(input logic [NCH-1:0] r, input logic [IW-1:0] start);
        logic [IW:0] res;
        int          k;
        res = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            k = (int'(start) + i) % NCH;
            if (r[k]) begin
                res = {1'b1, IW'(k)};
            end
        end
        return res;
    endfunction

    function automatic logic [NCH-1:0] gmask(input logic [IW-1:0] g);
        return NCH'(1) << g;
    endfunction

    // apb: one wait state; read data registered as pready rises, write data taken at the edge that samples pready high
    assign access   = PSEL & PENABLE;
    assign wr_fire  = access & ack_reg & PWRITE;
    assign rd_fire  = access & ack_reg & ~PWRITE;
    assign PREADY   = ack_reg;
    assign PSLVERR  = ack_reg & ~is_mapped(PADDR);
    assign PRDATA   = prdata_reg;

    assign mode_wr    = wr_fire && (PADDR == `ADDR_CTRL);
    assign mode_leave = mode_wr && (PWDATA[`CTRL_MODE_LSB +: 2] != `CLK_MODE_ARB);
    assign msg_done   = wr_fire && (PADDR == `ADDR_CMD) && (PWDATA[7:0] == `CMD_MSG_DONE);
    assign rx_reset   = wr_fire && (PADDR == `ADDR_CMD) && PWDATA[`CMD_RX_RESET_BIT];

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            prdata_reg <= 32'h0000_0000;
        end else if (access && !ack_reg && !PWRITE) begin
            case (PADDR)
                `ADDR_CTRL:     prdata_reg <= {29'h0, ctrl_reg};
                `ADDR_CHAN_EN:  prdata_reg <= 32'(chan_en_reg);
                `ADDR_IRQ_STAT: prdata_reg <= {30'h0, irq_stat_reg};
                `ADDR_IRQ_EN:   prdata_reg <= {30'h0, irq_en_reg};
                `ADDR_ARB_STAT: prdata_reg <= {8'h00, 8'(fifo_level), 8'(grant_reg), 5'h00, state_reg};
                `ADDR_RX_DATA:  prdata_reg <= {24'h0, fifo_rdata};
                default:        prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ctrl_reg    <= `CTRL_RESET;
            chan_en_reg <= '0;
            irq_en_reg  <= 2'h0;
        end else if (wr_fire) begin
            if (PADDR == `ADDR_CTRL) begin
                ctrl_reg <= PWDATA[2:0];
            end
            if (PADDR == `ADDR_CHAN_EN) begin
                chan_en_reg <= PWDATA[NCH-1:0];
            end
            if (PADDR == `ADDR_IRQ_EN) begin
                irq_en_reg <= PWDATA[1:0];
            end
        end
    end

    // channel requests arrive from the highway, so they are synchronised first
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            req_s1_reg <= '0;
            req_s2_reg <= '0;
        end else begin
            req_s1_reg <= D_REQ;
            req_s2_reg <= req_s1_reg;
        end
    end

    assign served = ctrl_reg[`CTRL_SERVE_ALL] ? chan_en_reg : (chan_en_reg & NCH'(1));
    assign req    = req_s2_reg & served;
    assign pick   = next_req(req, IW'(grant_reg + 1'b1));

    rx_deser u_deser (
        .clk      (CLK_SYS),
        .nrst     (NRST),
        .rx_clr   (rx_reset),
        .link_clk (LINK_CLK),
        .rxd      (RXD),
        .ev       (ev)
    );

    // frame end exists only as the status byte write; a full fifo swallows it
    assign frame_end_ind = ev.closing & ~fifo_full;
    assign lost_byte     = ev.byte_valid & fifo_full;
    assign lost_status   = ev.closing & fifo_full;
    assign stuck_frame   = stuck_reg && (state_reg == RECV_FRAME) && ev.frame_start;
    assign fifo_wr       = ev.byte_valid | ev.closing;
    assign fifo_wdata    = ev.closing ? `STATUS_OK : ev.data;
    assign fifo_rd       = rd_fire && (PADDR == `ADDR_RX_DATA) && !fifo_empty;

    rx_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
        .clk     (CLK_SYS),
        .nrst    (NRST),
        .flush   (rx_reset | msg_done),
        .wr_en   (fifo_wr),
        .wr_data (fifo_wdata),
        .rd_en   (fifo_rd),
        .rd_data (fifo_rdata),
        .full    (fifo_full),
        .empty   (fifo_empty),
        .level   (fifo_level)
    );

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            stuck_reg <= 1'b0;
        end else if (state_reg != RECV_FRAME) begin
            stuck_reg <= 1'b0;
        end else if (lost_status) begin
            stuck_reg <= 1'b1;
        end
    end

    // arbiter; a mode write away from arbitration overrides every state
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_reg <= STATE_B;
            grant_reg <= '0;
        end else if (mode_leave) begin
            state_reg <= STATE_B;
        end else begin
            case (state_reg)
                STATE_B: begin
                    if (ctrl_reg[`CTRL_MODE_LSB +: 2] == `CLK_MODE_ARB) begin
                        state_reg <= FULL_SEL;
                    end
                end
                FULL_SEL: begin
                    if (pick[IW]) begin
                        grant_reg <= pick[IW-1:0];
                        state_reg <= STATE_A;
                    end
                end
                STATE_A: begin
                    if (ev.frame_start) begin
                        state_reg <= RECV_FRAME;
                    end
                end
                RECV_FRAME: begin
                    // receiver reset alone never leaves this state
                    if (frame_end_ind || msg_done) begin
                        state_reg <= LIMITED_SEL;
                    end
                end
                LIMITED_SEL: begin
                    if (pick[IW]) begin
                        grant_reg <= pick[IW-1:0];
                        state_reg <= STATE_A;
                    end else begin
                        state_reg <= FULL_SEL;
                    end
                end
                default: state_reg <= STATE_B;
            endcase
        end
    end

    // blocked indication: the grantee alone may send once a choice is made
    always_comb begin
        case (state_reg)
            STATE_B:  blocked_next = '1;
            FULL_SEL: blocked_next = ~served;
            default:  blocked_next = ~gmask(grant_reg);
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            blocked_reg <= '1;
        end else begin
            blocked_reg <= blocked_next;
        end
    end

    assign BLOCKED = blocked_reg;

    // interrupts: set wins over a clear in the same cycle
    assign irq_set[`IRQ_MSG_END] = frame_end_ind;
    assign irq_set[`IRQ_RX_OVF]  = lost_byte | lost_status | stuck_frame;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_stat_reg <= 2'h0;
        end else if (wr_fire && (PADDR == `ADDR_IRQ_CLR)) begin
            irq_stat_reg <= (irq_stat_reg & ~PWDATA[1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    assign IRQ = |(irq_stat_reg & irq_en_reg);

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    sequence leave_mode_s;
        mode_leave;
    endsequence

    sequence recv_end_s;
        (state_reg == RECV_FRAME) && (frame_end_ind || msg_done) && !mode_leave;
    endsequence

    mode_suspends_a: assert property (leave_mode_s |=> state_reg == STATE_B)
        else $error("mode write did not suspend arbiter");
    stay_state_b_a: assert property ((state_reg == STATE_B && ctrl_reg[2:1] != 2'h3) |=> state_reg == STATE_B)
        else $error("arbiter left state_b without arbitration mode");
    flag_to_recv_a: assert property ((state_reg == STATE_A && ev.frame_start && !mode_leave)
                                     |=> state_reg == RECV_FRAME)
        else $error("opening flag did not enter receive frame");
    end_to_limited_a: assert property (recv_end_s |=> state_reg == LIMITED_SEL ##1 state_reg != RECV_FRAME)
        else $error("frame end did not reach limited selection");
    no_room_stays_a: assert property ((state_reg == RECV_FRAME && lost_status && !msg_done && !mode_leave)
                                      |=> state_reg == RECV_FRAME && stuck_reg)
        else $error("arbiter left receive frame without status byte");
    end_has_status_a: assert property (irq_set[0] |-> fifo_wr && !fifo_full && fifo_wdata == 8'hA0)
        else $error("frame end without status byte write");
    stuck_ovf_irq_a: assert property (stuck_frame |=> irq_stat_reg[1] && state_reg inside {RECV_FRAME, STATE_B})
        else $error("stuck frame did not raise overflow");
    stuck_blocks_a: assert property ((state_reg == RECV_FRAME)[*2] |-> BLOCKED == ~gmask(grant_reg))
        else $error("blocked indication wrong in receive frame");
    rx_reset_keeps_a: assert property ((state_reg == RECV_FRAME && rx_reset && !mode_leave && !msg_done)
                                       |=> state_reg == RECV_FRAME)
        else $error("receiver reset moved arbiter");
    grant_served_a: assert property ((state_reg == FULL_SEL && pick[IW] && !mode_leave)
                                     |=> state_reg == STATE_A && served[grant_reg])
        else $error("grant to unserved channel");

endmodule

// ==== tb/dch_term_model.sv ====
// subscriber terminal model driving the serial highway
`timescale 1ns/1ns

module dch_term_model (
    // highway
    output logic link_clk,
    output logic rxd
);
    initial begin
        link_clk = 1'h0;
        rxd = 1'h1;
    end
    // lsb first; data changes while the clock is low so the rise sees it settled
    task automatic send(input logic [7:0] b);
        int i;
        #13;
        for (i = 0; i < 8; i++) begin
            rxd = b[i];
            #200 link_clk = 1'h1;
            #200 link_clk = 1'h0;
        end
    endtask
    // clock stands still between frames; line flips so a stale bit cannot pass as data
    task automatic idle();
        rxd = ~rxd;
    endtask
endmodule

// ==== tb/tb_dchannel_arbiter_overflow.sv ====
// bench for the d-channel arbiter: registers, arbitration and overflow recovery
`timescale 1ns/1ns
`include "dch_arb_consts.svh"

module tb_dchannel_arbiter_overflow;
    logic        clk = 1'h0;
    logic        nrst = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rq;
    logic        pready;
    logic        pslverr;
    logic        re;
    logic        irq;
    logic        lclk;
    logic        rxd;
    logic [3:0]  dreq = 4'h0;
    logic [3:0]  blk;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          g1;
    int          g2;
    int          i;
    // address, write data, expected read, expected error
    logic [72:0] rows [5] = '{
        {8'h04, 32'hF, 32'hF, 1'h0},
        {8'h14, 32'h3, 32'h3, 1'h0},
        {8'h00, 32'h5, 32'h5, 1'h0},
        {8'h0C, 32'h3, 32'h0, 1'h0},
        {8'h20, 32'h1, 32'h0, 1'h1}
    };

    always #25 clk = ~clk;

    dch_term_model i_term (.link_clk(lclk), .rxd(rxd));

    // small fifo so a five-byte frame overflows it
    dch_arbiter #(.NCH(4), .DEPTH(4)) i_dut (
        .CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LINK_CLK(lclk), .RXD(rxd), .D_REQ(dreq), .BLOCKED(blk), .IRQ(irq));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until the rising edge that samples pready high; data and error taken there
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            error_cnt++;
            $display("mismatch at %0t: bus not answering", $time);
            report_and_stop();
        end else begin
            rq = prdata;
            re = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    task automatic wait_st(input logic [2:0] s);
        int k;
        for (k = 0; k < 80; k++) begin
            apb(1'h0, 8'h18, 32'h0);
            if (rq[2:0] === s)
                break;
        end
        chk(rq[2:0], s);
        if (rq[2:0] !== s)
            report_and_stop();
    endtask

    task automatic wait_irq();
        int k;
        for (k = 0; k < 400; k++) begin
            @(negedge clk);
            if (irq === 1'h1)
                break;
        end
        chk(irq, 1'h1);
        if (irq !== 1'h1)
            report_and_stop();
    endtask

    task automatic tx(input logic [7:0] q[$]);
        foreach (q[k])
            i_term.send(q[k]);
        i_term.idle();
    endtask

    initial begin
        repeat (20) @(posedge clk);
        chk(blk, 4'hF);
        chk(irq, 1'h0);
        nrst <= 1'h1;
        apb(1'h0, 8'h18, 32'h0);
        chk(rq[2:0], 3'h0);
        for (i = 0; i < 5; i++) begin
            apb(1'h1, rows[i][72:65], rows[i][64:33]);
            apb(1'h0, rows[i][72:65], 32'h0);
            chk(rq, rows[i][32:1]);
            chk(re, rows[i][0]);
        end
        apb(1'h0, 8'h18, 32'h0);
        chk(rq[2:0], 3'h0);
        apb(1'h1, 8'h04, 32'h6);
        apb(1'h1, 8'h00, 32'h7);
        wait_st(3'h1);
        // disabled channels 0 and 3 request as well and must never win
        dreq <= 4'hF;
        wait_st(3'h2);
        g1 = rq[15:8];
        g2 = 3 - g1;
        chk(g1 == 1 || g1 == 2, 1'h1);
        chk(blk, 4'hF ^ (4'h1 << g1));
        tx('{`FLAG_BYTE, 8'h55});
        wait_st(3'h3);
        apb(1'h0, 8'h0C, 32'h0);
        chk(rq[0], 1'h0);
        tx('{`FLAG_BYTE});
        wait_st(3'h2);
        chk(rq[15:8], g2);
        chk(blk, 4'hF ^ (4'h1 << g2));
        apb(1'h0, 8'h0C, 32'h0);
        chk(rq[1:0], 2'h1);
        @(negedge clk);
        chk(irq, 1'h1);
        apb(1'h0, 8'h1C, 32'h0);
        chk(rq[7:0], 8'h55);
        apb(1'h0, 8'h1C, 32'h0);
        chk(rq[7:0], `STATUS_OK);
        apb(1'h1, 8'h14, 32'h2);
        @(negedge clk);
        chk(irq, 1'h0);
        apb(1'h1, 8'h10, 32'h1);
        apb(1'h0, 8'h0C, 32'h0);
        chk(rq[1:0], 2'h0);
        apb(1'h1, 8'h14, 32'h3);
        tx('{`FLAG_BYTE, 8'h11, 8'h22, 8'h33, 8'h44});
        wait_st(3'h3);
        tx('{`FLAG_BYTE});
        wait_irq();
        apb(1'h0, 8'h18, 32'h0);
        chk(rq[2:0], 3'h3);
        chk(rq[23:16], 8'h4);
        chk(blk, 4'hF ^ (4'h1 << g2));
        apb(1'h0, 8'h0C, 32'h0);
        chk(rq[1:0], 2'h2);
        apb(1'h1, 8'h10, 32'h3);
        @(negedge clk);
        chk(irq, 1'h0);
        tx('{`FLAG_BYTE, 8'h19});
        wait_irq();
        chk(blk, 4'hF ^ (4'h1 << g2));
        tx('{`FLAG_BYTE});
        apb(1'h1, 8'h08, 32'h40);
        apb(1'h0, 8'h18, 32'h0);
        chk(rq[2:0], 3'h3);
        chk(rq[23:16], 8'h0);
        // after the second overflow frame and a receiver reset, software releases the stuck channel
        apb(1'h1, 8'h08, 32'h80);
        apb(1'h0, 8'h18, 32'h0);
        chk(rq[2:0] == 3'h4 || rq[2:0] == 3'h2, 1'h1);
        wait_st(3'h2);
        chk(rq[15:8], g1);
        tx('{`FLAG_BYTE, 8'h12});
        wait_st(3'h3);
        apb(1'h1, 8'h00, 32'h3);
        apb(1'h0, 8'h18, 32'h0);
        chk(rq[2:0], 3'h0);
        chk(blk, 4'hF);
        nrst <= 1'h0;
        dreq <= 4'h0;
        repeat (2) @(posedge clk);
        chk(irq, 1'h0);
        chk(blk, 4'hF);
        nrst <= 1'h1;
        apb(1'h0, 8'h00, 32'h0);
        chk(rq, 32'h0);
        apb(1'h0, 8'h18, 32'h0);
        chk(rq[2:0], 3'h0);
        // serve-all clear: channel 1 is enabled but only channel 0 may be granted
        apb(1'h1, 8'h04, 32'h3);
        apb(1'h1, 8'h00, 32'h6);
        dreq <= 4'hF;
        wait_st(3'h2);
        chk(rq[15:8], 8'h0);
        chk(blk, 4'hE);
        report_and_stop();
    end
endmodule
